// ---- bench/fmc_exec_props.sv ----
// port assertions for the executor
`timescale 1ns/1ns
module fmc_exec_props (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire fmc_pkg::fmc_dmem_type DMEM_REQ,
    input wire fmc_pkg::fmc_pmem_type PMEM_REQ,
    input wire logic SLEEP_REQ,
    input wire logic WDT_RESTART
);
    import fmc_pkg::*;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);
    a_ack_wait: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=>
        WB_ACK_O) else $error("ack missing");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held");
    a_ack_idle: assert property (!WB_STB_I |=> !WB_ACK_O)
        else $error("ack without request");
    a_dmem_once: assert property ($rose(DMEM_REQ.re || DMEM_REQ.we) |=>
        !(DMEM_REQ.re || DMEM_REQ.we)) else $error("dmem strobe long");
    a_dmem_excl: assert property (!(DMEM_REQ.re && DMEM_REQ.we))
        else $error("dmem read and write");
    a_code_once: assert property (PMEM_REQ.re |=> !PMEM_REQ.re [*2])
        else $error("code read repeated");
    a_sleep_once: assert property (SLEEP_REQ |=> !SLEEP_REQ)
        else $error("sleep pulse long");
    a_wdt_once: assert property ($rose(WDT_RESTART) |=> $fell(WDT_RESTART))
        else $error("restart pulse long");
endmodule // fmc_exec_props

// ---- bench/fmc_mem_model.sv ----
// data, code and i/o space model
`timescale 1ns/1ns
module fmc_mem_model (
    input wire logic CORE_CLK,
    input wire fmc_pkg::fmc_dmem_type DMEM_REQ,
    output logic [7:0] DMEM_RDATA,
    input wire fmc_pkg::fmc_pmem_type PMEM_REQ,
    output logic [7:0] PMEM_RDATA,
    output logic PMEM_DONE = 1'b0,
    input wire fmc_pkg::fmc_io_type IO_REQ,
    output logic [7:0] IO_RDATA
);
    import fmc_pkg::*;
    logic [7:0] mem [256]; // data bytes, low address byte only
    logic [7:0] junk = 8'h00; // moves each cycle
    logic [1:0] wcnt = 2'h0; // code write wait
    // writes; junk keeps stale reads from passing
    always @(posedge CORE_CLK) begin
        junk <= junk + 8'h4b;
        if (DMEM_REQ.we) mem[DMEM_REQ.addr[7:0]] <= DMEM_REQ.wdata;
    end
    assign DMEM_RDATA = DMEM_REQ.re ? mem[DMEM_REQ.addr[7:0]] : junk;
    assign IO_RDATA = IO_REQ.re ? {2'h2, IO_REQ.addr} : ~junk;
    // code byte one cycle late, write ends after a wait
    always @(posedge CORE_CLK) begin
        PMEM_RDATA <= PMEM_REQ.re ? PMEM_REQ.addr[7:0] ^ 8'h3c : junk;
        wcnt <= PMEM_REQ.we ? wcnt + 2'h1 : 2'h0;
        PMEM_DONE <= PMEM_REQ.we && wcnt == 2'h2;
    end
endmodule // fmc_mem_model

// ---- bench/test_fmc_exec.sv ----
// self-checking bench for the executor
`timescale 1ns/1ns
module test_fmc_exec;
    import fmc_pkg::*;
    logic CORE_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic cyc = 1'b0, we = 1'b0, rsm = 1'b0, ack, pdone, slp, wdt, hlt;
    logic [7:0] adr = 8'h00, drd, prd, iord;
    logic [31:0] dat = 32'h0, dout, q;
    fmc_dmem_type dreq;
    fmc_pmem_type preq;
    fmc_io_type ioreq;
    int mismatches = 0, n_tests = 0, n_slp = 0, n_wdt = 0;
    always #4 CORE_CLK = ~CORE_CLK;
    fmc_exec u_dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .WB_CYC_I(cyc),
        .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
        .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .DMEM_REQ(dreq),
        .DMEM_RDATA(drd), .PMEM_REQ(preq), .PMEM_RDATA(prd),
        .PMEM_DONE(pdone), .IO_REQ(ioreq), .IO_RDATA(iord),
        .SLEEP_REQ(slp), .WDT_RESTART(wdt), .DBG_HALTED(hlt),
        .DBG_RESUME(rsm));
    fmc_mem_model u_mem (.CORE_CLK(CORE_CLK), .DMEM_REQ(dreq),
        .DMEM_RDATA(drd), .PMEM_REQ(preq), .PMEM_RDATA(prd),
        .PMEM_DONE(pdone), .IO_REQ(ioreq), .IO_RDATA(iord));
    // count control pulses
    always @(posedge CORE_CLK) begin
        n_slp <= n_slp + int'(slp === 1'b1);
        n_wdt <= n_wdt + int'(wdt === 1'b1);
    end
    task automatic chk(input string w, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", w, e, s);
        end
    endtask
    // one classic cycle; read data lands in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) mismatches++;
        q = dout;
        cyc <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    // issue and wait for busy to drop
    task automatic ex(input logic [31:0] ins);
        int n = 0;
        wb(1'b1, ADR_INSTR, ins);
        do begin
            wb(1'b0, ADR_STATUS, 32'h0);
            n++;
        end while (q[STAT_BUSY] !== 1'b0 && n < 20);
        if (q[STAT_BUSY] !== 1'b0) mismatches++;
    endtask
    task automatic rput(input logic [4:0] i, input logic [7:0] v);
        wb(1'b1, ADR_REGACC, {15'h0, 1'b1, 3'h0, i, v});
    endtask
    task automatic rget(input logic [4:0] i);
        wb(1'b1, ADR_REGACC, {19'h0, i, 8'h00});
        wb(1'b0, ADR_REGACC, 32'h0);
    endtask
    // all set ops then all clear ops, one flag each
    task automatic t_flags;
        logic [7:0] e;
        e = 8'h00;
        wb(1'b1, ADR_STATUS_REGISTER, 32'h0);
        for (int s = 0; s < 16; s++) begin
            ex(32'h9408 | (s << 4));
            e[s % 8] = (s < 8);
            wb(1'b0, ADR_STATUS_REGISTER, 32'h0);
            chk("status_register", q[7:0], e);
        end
        $display("t_flags done");
    endtask
    // pointer forms through X and Y
    task automatic t_ptr;
        u_mem.mem[8'h10] = 8'ha5;
        u_mem.mem[8'h25] = 8'hc3;
        rput(PTR_X, 8'h10);
        rput(PTR_Y, 8'h20);
        rput(5'h06, 8'h3c);
        ex(32'h905d);
        rget(5'h05);
        chk("r5", q[7:0], 8'ha5);
        rget(PTR_X);
        chk("x post", q[7:0], 8'h11);
        ex(32'h926e);
        rget(PTR_X);
        chk("x pre", q[7:0], 8'h10);
        chk("mem 10", u_mem.mem[8'h10], 8'h3c);
        ex(32'h807d);
        rget(5'h07);
        chk("r7", q[7:0], 8'hc3);
        rget(PTR_Y);
        chk("y kept", q[7:0], 8'h20);
        $display("t_ptr done");
    endtask
    // direct forms, stack, variant gate
    task automatic t_dir;
        u_mem.mem[8'h30] = 8'h99;
        ex(32'h0030_9080);
        ex(32'h0040_9280);
        chk("mem 40", u_mem.mem[8'h40], 8'h99);
        ex(32'h928f);
        ex(32'h909f);
        rget(5'h09);
        chk("r9", q[7:0], 8'h99);
        wb(1'b0, ADR_STATUS_REGISTER, 32'h0);
        chk("flags", q[7:0], 8'h00);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk("sp", q[31:16], SP_RESET);
        wb(1'b1, ADR_CTRL, 32'h0);
        ex(32'h0030_90a0);
        chk("bad", q[STAT_BAD], 1'b1);
        rget(5'h0a);
        chk("r10", q[7:0], 8'h00);
        $display("t_dir done");
    endtask
    // code read, i/o read, sleep, restart, unmapped
    task automatic t_ctl;
        rput(PTR_Z, 8'h12);
        ex(32'h95c8);
        rget(REG_R0);
        chk("r0", q[7:0], 8'h12 ^ 8'h3c);
        ex(32'hb0b5);
        rget(5'h0b);
        chk("r11", q[7:0], 8'h85);
        ex(32'h9588);
        ex(32'h95a8);
        chk("sleeps", n_slp, 1);
        chk("restarts", n_wdt, 1);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", q, 32'h0);
        ex(32'h95e8);
        wb(1'b1, ADR_INSTR, 32'h9598);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk("halt", {q[STAT_HALT], hlt}, 2'h3);
        rsm <= 1'b1;
        repeat (2) wb(1'b0, ADR_STATUS, 32'h0);
        chk("resume", {q[1:0], hlt}, 3'h0);
        $display("t_ctl done");
    endtask
    task automatic conclude;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog far beyond the expected few hundred cycles
    initial begin
        #200000;
        mismatches++;
        conclude;
    end
    initial begin
        repeat (8) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        @(posedge CORE_CLK);
        t_flags;
        t_ptr;
        t_dir;
        t_ctl;
        conclude;
    end
endmodule // test_fmc_exec
bind fmc_exec fmc_exec_props u_props (.CORE_CLK(CORE_CLK),
    .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .DMEM_REQ(DMEM_REQ), .PMEM_REQ(PMEM_REQ),
    .SLEEP_REQ(SLEEP_REQ), .WDT_RESTART(WDT_RESTART));

// ---- rtl/fmc_exec.sv ----
// flag, move and control instruction executor with a wishbone slave
`timescale 1ns/1ns

// Notes on behaviour
// - sign-flag set/clear touches S only, one cycle
// - overflow set/clear touches V only, one cycle
// - half-carry set/clear touches H only, one cycle
// - each flag clear changes one flag, one cycle
// - post-increment load reads then bumps pointer
// - pre-decrement load drops pointer then reads
// - displaced load reads Y/Z plus q, pointer kept
// - post-increment store writes then bumps pointer
// - pre-decrement store drops pointer then writes
// - displaced store writes Y/Z plus q, pointer kept
// - direct load from instruction address, two cycles
// - direct store to instruction address, two cycles
// - code read via Z, optional increment, three cycles
// - stack push in two cycles, no flags
// - stack pop in two cycles, no flags
// - sleep issues in one cycle, requests sleep
// - watchdog restart one cycle, pulses restart
// - debug halt serves debug only, no count
// - direct load and store exist only in large variant
module fmc_exec (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output fmc_pkg::fmc_dmem_type DMEM_REQ,
    input wire logic [7:0] DMEM_RDATA,
    output fmc_pkg::fmc_pmem_type PMEM_REQ,
    input wire logic [7:0] PMEM_RDATA,
    input wire logic PMEM_DONE,
    output fmc_pkg::fmc_io_type IO_REQ,
    input wire logic [7:0] IO_RDATA,
    output logic SLEEP_REQ,
    output logic WDT_RESTART,
    output logic DBG_HALTED,
    input wire logic DBG_RESUME
);
    import fmc_pkg::*;

    logic [7:0] rf [32]; // working registers
    logic [7:0] status_register; // status register
    logic [15:0] sp; // stack pointer
    logic [31:0] instr_q; // opcode plus second word
    logic big_variant; // large-family instructions on
    logic bad_flag; // sticky: unknown or absent opcode
    logic [4:0] ra_idx; // register window index
    fmc_state_type state, next_state;
    fmc_op_type op;
    fmc_dmem_type dm_q, next_dm;
    fmc_pmem_type pm_q, next_pm;
    logic resume_m, resume_s; // resume synchroniser

    // exec write ports and side effects
    logic rfb_we, rfw_we, status_register_we, status_register_val, bad_set;
    logic [4:0] rfb_idx, rfw_idx;
    logic [7:0] rfb_data;
    logic [15:0] rfw_data, next_sp;

    // operand fields
    logic [15:0] opc;
    logic [3:0] nib;
    logic [4:0] dst, src, ptr_lo;
    logic [15:0] ptr_val, ptr_inc, ptr_dec;
    logic [5:0] disp;
    logic [2:0] flag_sel;

    ////////////////////////////////////////////////////////////////
    // bus slave

    logic bus_req, wr_fire, idle;
    assign bus_req = WB_CYC_I & WB_STB_I;
    // write acts at the edge where ack is seen high
    assign wr_fire = bus_req & WB_WE_I & WB_ACK_O;
    assign idle = (state == STA_IDLE);

    // ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req & ~WB_ACK_O;
        end
    end

    // read data registered with the ack; unmapped reads zero
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (bus_req & ~WB_ACK_O) begin
            case (WB_ADR_I)
                ADR_INSTR: WB_DAT_O <= instr_q;
                ADR_CTRL: WB_DAT_O <= {31'h0000_0000, big_variant};
                ADR_STATUS_REGISTER: WB_DAT_O <= {24'h00_0000, status_register};
                ADR_REGACC: WB_DAT_O <= {19'h0_0000, ra_idx, rf[ra_idx]};
                ADR_STATUS: WB_DAT_O <= {sp, 13'h0000, bad_flag,
                                         state == STA_HALT, ~idle};
                default: WB_DAT_O <= 32'h0000_0000;
            endcase
        end
    end

    // variant control bit
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            big_variant <= CTRL_BIG_RESET;
        end else if (wr_fire && WB_ADR_I == ADR_CTRL && WB_SEL_I[0]) begin
            big_variant <= WB_DAT_I[CTRL_BIG];
        end
    end

    // instruction launch; refused silently while busy
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            instr_q <= 32'h0000_0000;
        end else if (wr_fire && WB_ADR_I == ADR_INSTR && idle
                     && WB_SEL_I == 4'hf) begin
            instr_q <= WB_DAT_I;
        end
    end

    // register window index
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ra_idx <= 5'h00;
        end else if (wr_fire && WB_ADR_I == ADR_REGACC && WB_SEL_I[1]) begin
            ra_idx <= WB_DAT_I[12:8];
        end
    end

    // sticky error flag; a new error beats the clear
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bad_flag <= 1'b0;
        end else if (bad_set) begin
            bad_flag <= 1'b1;
        end else if (wr_fire && WB_ADR_I == ADR_STATUS && WB_SEL_I[0]
                     && WB_DAT_I[STAT_BAD]) begin
            bad_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // decode

    assign opc = instr_q[15:0];
    assign nib = opc[3:0];
    assign dst = opc[8:4];
    assign flag_sel = opc[6:4];
    assign disp = {opc[13], opc[11:10], opc[2:0]};

    // opcode to operation; more specific patterns first
    always_comb begin
        op = OP_ILLEGAL;
        casez (opc)
            PAT_FLAG_ONE: op = OP_FLAG_ONE;
            PAT_FLAG_LOW: op = OP_FLAG_LOW;
            PAT_DOZE: op = OP_DOZE;
            PAT_DBG: op = OP_DEBUG_HALT;
            PAT_WDOG: op = OP_WD_RESTART;
            PAT_CODE_R0: op = OP_CODE_READ;
            PAT_CODE_WR: op = OP_CODE_WRITE;
            PAT_IDLE: op = OP_IDLE;
            PAT_PAIR: op = OP_PAIR_COPY;
            PAT_COPY: op = OP_REG_COPY;
            PAT_IMM: op = OP_IMM_LOAD;
            PAT_PIN: op = OP_PORT_IN;
            PAT_POUT: op = OP_PORT_OUT;
            PAT_DIR_RD: op = OP_DIR_READ;
            PAT_DIR_WR: op = OP_DIR_WRITE;
            PAT_CODE_RD: op = OP_CODE_READ;
            PAT_POP: op = OP_STACK_GET;
            PAT_PUSH: op = OP_STACK_PUT;
            PAT_IND_RD: op = OP_IND_READ;
            PAT_IND_WR: op = OP_IND_WRITE;
            PAT_DSP_RD: op = OP_DSP_READ;
            PAT_DSP_WR: op = OP_DSP_WRITE;
            default: op = OP_ILLEGAL;
        endcase
        // only X, X+, -X, Y+, -Y, Z+, -Z exist as plain indirect
        if ((op == OP_IND_READ || op == OP_IND_WRITE)
            && (nib[3:2] == 2'b01 || nib[1:0] == 2'b11
                || (nib[1:0] == 2'b00 && nib[3:2] != 2'b11))) begin
            op = OP_ILLEGAL;
        end
        // two-word direct forms exist only in the large variant
        if (!big_variant && (op == OP_DIR_READ || op == OP_DIR_WRITE)) begin
            op = OP_ILLEGAL;
        end
    end

    // pointer choice: X/Y/Z by mode nibble, Y/Z for displaced
    always_comb begin
        ptr_lo = PTR_Z;
        if (op == OP_IND_READ || op == OP_IND_WRITE) begin
            if (nib[3:2] == 2'b11) begin
                ptr_lo = PTR_X;
            end else if (nib[3]) begin
                ptr_lo = PTR_Y;
            end
        end else if (op == OP_DSP_READ || op == OP_DSP_WRITE) begin
            ptr_lo = nib[3] ? PTR_Y : PTR_Z;
        end
    end

    assign ptr_val = {rf[ptr_lo | 5'h01], rf[ptr_lo]};
    assign ptr_inc = ptr_val + 16'h0001;
    assign ptr_dec = ptr_val - 16'h0001;
    // store-type forms carry the source in the destination field
    assign src = (op == OP_REG_COPY) ? {opc[9], opc[3:0]} : dst;

    // i/o strobes act inside the single execute cycle
    assign IO_REQ.addr = {opc[10:9], opc[3:0]};
    assign IO_REQ.wdata = rf[dst];
    assign IO_REQ.re = (state == STA_EX1) && (op == OP_PORT_IN);
    assign IO_REQ.we = (state == STA_EX1) && (op == OP_PORT_OUT);
    assign SLEEP_REQ = (state == STA_EX1) && (op == OP_DOZE);
    assign WDT_RESTART = (state == STA_EX1)
                         && (op == OP_WD_RESTART);
    assign DBG_HALTED = (state == STA_HALT);
    assign DMEM_REQ = dm_q;
    assign PMEM_REQ = pm_q;

    ////////////////////////////////////////////////////////////////
    // execute sequence

    // next state, register writes and memory requests
    always_comb begin
        next_state = state;
        next_dm = '0;
        next_pm = '0;
        next_sp = sp;
        rfb_we = 1'b0;
        rfb_idx = dst;
        rfb_data = 8'h00;
        rfw_we = 1'b0;
        rfw_idx = ptr_lo;
        rfw_data = ptr_val;
        status_register_we = 1'b0;
        status_register_val = 1'b0;
        bad_set = 1'b0;
        case (state)
            STA_IDLE: begin
                if (wr_fire && WB_ADR_I == ADR_INSTR && WB_SEL_I == 4'hf) begin
                    next_state = STA_EX1;
                end
            end
            STA_EX1: begin
                next_state = STA_IDLE; // one-cycle forms end here
                case (op)
                    // one flag only, others kept
                    OP_FLAG_ONE, OP_FLAG_LOW: begin
                        status_register_we = 1'b1;
                        status_register_val = (op == OP_FLAG_ONE);
                    end
                    OP_REG_COPY: begin
                        rfb_we = 1'b1;
                        rfb_data = rf[src];
                    end
                    OP_PAIR_COPY: begin
                        rfw_we = 1'b1;
                        rfw_idx = {opc[7:4], 1'b0};
                        rfw_data = {rf[{opc[3:0], 1'b1}], rf[{opc[3:0], 1'b0}]};
                    end
                    OP_IMM_LOAD: begin
                        rfb_we = 1'b1;
                        rfb_idx = IMM_BASE | {1'b0, opc[7:4]};
                        rfb_data = {opc[11:8], opc[3:0]};
                    end
                    OP_PORT_IN: begin
                        rfb_we = 1'b1;
                        rfb_data = IO_RDATA;
                    end
                    OP_IND_READ, OP_IND_WRITE: begin
                        next_state = STA_EX2;
                        next_dm.re = (op == OP_IND_READ);
                        next_dm.we = (op == OP_IND_WRITE);
                        next_dm.wdata = rf[src];
                        // pre-decrement uses the lowered pointer
                        next_dm.addr = nib[1] ? ptr_dec
                                              : ptr_val;
                        rfw_we = nib[1] | nib[0];
                        rfw_data = nib[1] ? ptr_dec
                                          : ptr_inc;
                    end
                    OP_DSP_READ, OP_DSP_WRITE: begin
                        next_state = STA_EX2; // pointer untouched
                        next_dm.re = (op == OP_DSP_READ);
                        next_dm.we = (op == OP_DSP_WRITE);
                        next_dm.wdata = rf[src];
                        next_dm.addr = ptr_val + {10'h000, disp};
                    end
                    OP_DIR_READ, OP_DIR_WRITE: begin
                        next_state = STA_EX2;
                        next_dm.re = (op == OP_DIR_READ);
                        next_dm.we = (op == OP_DIR_WRITE);
                        next_dm.wdata = rf[src];
                        next_dm.addr = instr_q[31:16];
                    end
                    OP_STACK_PUT: begin
                        next_state = STA_EX2;
                        next_dm.we = 1'b1;
                        next_dm.wdata = rf[src];
                        next_dm.addr = sp;
                        next_sp = sp - 16'h0001;
                    end
                    OP_STACK_GET: begin
                        next_state = STA_EX2;
                        next_dm.re = 1'b1;
                        next_dm.addr = sp + 16'h0001;
                        next_sp = sp + 16'h0001;
                    end
                    OP_CODE_READ: begin
                        next_state = STA_EX2;
                        next_pm.re = 1'b1;
                        next_pm.addr = ptr_val;
                        // only the Z+ form advances the pointer
                        rfw_we = (opc != PAT_CODE_R0) && nib[0];
                        rfw_data = ptr_inc;
                    end
                    OP_CODE_WRITE: begin
                        next_state = STA_CODE_WAIT;
                        next_pm.we = 1'b1;
                        next_pm.addr = ptr_val;
                        next_pm.wdata = {rf[REG_R1], rf[REG_R0]};
                    end
                    OP_DEBUG_HALT: next_state = STA_HALT;
                    OP_ILLEGAL: bad_set = 1'b1;
                    default: next_state = STA_IDLE;
                endcase
            end
            STA_EX2: begin
                next_state = STA_IDLE;
                // memory answered combinationally during this cycle
                if (dm_q.re) begin
                    rfb_we = 1'b1;
                    rfb_data = DMEM_RDATA;
                end
                if (pm_q.re) begin
                    next_state = STA_EX3; // code read has one more cycle
                end
            end
            STA_EX3: begin
                next_state = STA_IDLE;
                rfb_we = 1'b1;
                rfb_idx = (opc == PAT_CODE_R0) ? REG_R0 : dst;
                rfb_data = PMEM_RDATA;
            end
            STA_CODE_WAIT: begin
                // duration set by the program memory's own done
                next_pm = pm_q;
                if (PMEM_DONE) begin
                    next_pm = '0;
                    next_state = STA_IDLE;
                end
            end
            STA_HALT: begin
                // left only on the debugger's resume
                if (resume_s) begin
                    next_state = STA_IDLE;
                end
            end
            default: next_state = STA_IDLE;
        endcase
    end

    // sequence state
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= STA_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // memory requests come from flops, high for one access cycle; a code write is held until PMEM_DONE
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            dm_q <= '0;
            pm_q <= '0;
        end else begin
            dm_q <= next_dm;
            pm_q <= next_pm;
        end
    end

    // stack pointer
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sp <= SP_RESET;
        end else begin
            sp <= next_sp;
        end
    end

    // status register: software writes only while idle
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            status_register <= STATUS_REGISTER_RESET;
        end else if (status_register_we) begin
            status_register[flag_sel] <= status_register_val;
        end else if (idle && wr_fire && WB_ADR_I == ADR_STATUS_REGISTER
                     && WB_SEL_I[0]) begin
            status_register <= WB_DAT_I[7:0];
        end
    end

    // working registers; exec and bus never write in one cycle
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < 32; i++) begin
                rf[i] <= 8'h00;
            end
        end else begin
            if (idle && wr_fire && WB_ADR_I == ADR_REGACC
                && WB_SEL_I[2] && WB_DAT_I[RA_WE]) begin
                rf[WB_DAT_I[12:8]] <= WB_DAT_I[7:0];
            end
            if (rfw_we) begin
                rf[rfw_idx] <= rfw_data[7:0];
                rf[rfw_idx | 5'h01] <= rfw_data[15:8];
            end
            if (rfb_we) begin
                rf[rfb_idx] <= rfb_data;
            end
        end
    end

    // two-stage synchroniser for the external resume pin
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            resume_m <= 1'b0;
            resume_s <= 1'b0;
        end else begin
            resume_m <= DBG_RESUME;
            resume_s <= resume_m;
        end
    end

endmodule // fmc_exec

// ---- rtl/fmc_pkg.sv ----
// constants, opcode patterns and carrier types for the flag/move executor
package fmc_pkg;

    // register offsets on the bus (byte addresses)
    localparam logic [7:0] ADR_INSTR = 8'h00;
    localparam logic [7:0] ADR_CTRL = 8'h04;
    localparam logic [7:0] ADR_STATUS_REGISTER = 8'h08;
    localparam logic [7:0] ADR_REGACC = 8'h0c;
    localparam logic [7:0] ADR_STATUS = 8'h10;

    // field positions inside the bus registers
    localparam int CTRL_BIG = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_HALT = 1;
    localparam int STAT_BAD = 2;
    localparam int RA_WE = 16;

    // reset values
    localparam logic CTRL_BIG_RESET = 1'b1;
    localparam logic [7:0] STATUS_REGISTER_RESET = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h00ff;

    // register file indices of the pointer pairs and fixed operands
    localparam logic [4:0] PTR_X = 5'h1a;
    localparam logic [4:0] PTR_Y = 5'h1c;
    localparam logic [4:0] PTR_Z = 5'h1e;
    localparam logic [4:0] IMM_BASE = 5'h10;
    localparam logic [4:0] REG_R0 = 5'h00;
    localparam logic [4:0] REG_R1 = 5'h01;

    // opcode patterns, don't-care bits as ?
    localparam logic [15:0] PAT_FLAG_ONE = 16'b1001_0100_0???_1000;
    localparam logic [15:0] PAT_FLAG_LOW = 16'b1001_0100_1???_1000;
    localparam logic [15:0] PAT_DOZE = 16'b1001_0101_1000_1000;
    localparam logic [15:0] PAT_DBG = 16'b1001_0101_1001_1000;
    localparam logic [15:0] PAT_WDOG = 16'b1001_0101_1010_1000;
    localparam logic [15:0] PAT_CODE_R0 = 16'b1001_0101_1100_1000;
    localparam logic [15:0] PAT_CODE_WR = 16'b1001_0101_1110_1000;
    localparam logic [15:0] PAT_IDLE = 16'b0000_0000_0000_0000;
    localparam logic [15:0] PAT_PAIR = 16'b0000_0001_????_????;
    localparam logic [15:0] PAT_COPY = 16'b0010_11??_????_????;
    localparam logic [15:0] PAT_IMM = 16'b1110_????_????_????;
    localparam logic [15:0] PAT_PIN = 16'b1011_0???_????_????;
    localparam logic [15:0] PAT_POUT = 16'b1011_1???_????_????;
    localparam logic [15:0] PAT_DIR_RD = 16'b1001_000?_????_0000;
    localparam logic [15:0] PAT_DIR_WR = 16'b1001_001?_????_0000;
    localparam logic [15:0] PAT_CODE_RD = 16'b1001_000?_????_010?;
    localparam logic [15:0] PAT_POP = 16'b1001_000?_????_1111;
    localparam logic [15:0] PAT_PUSH = 16'b1001_001?_????_1111;
    localparam logic [15:0] PAT_IND_RD = 16'b1001_000?_????_????;
    localparam logic [15:0] PAT_IND_WR = 16'b1001_001?_????_????;
    localparam logic [15:0] PAT_DSP_RD = 16'b10?0_??0?_????_????;
    localparam logic [15:0] PAT_DSP_WR = 16'b10?0_??1?_????_????;

    // execution sequence
    typedef enum logic [2:0] {
        STA_IDLE, STA_EX1, STA_EX2, STA_EX3, STA_CODE_WAIT, STA_HALT
    } fmc_state_type;

    // decoded operation
    typedef enum logic [4:0] {
        OP_FLAG_ONE, OP_FLAG_LOW, OP_REG_COPY, OP_PAIR_COPY, OP_IMM_LOAD,
        OP_IND_READ, OP_IND_WRITE, OP_DSP_READ, OP_DSP_WRITE,
        OP_DIR_READ, OP_DIR_WRITE, OP_CODE_READ, OP_CODE_WRITE,
        OP_PORT_IN, OP_PORT_OUT, OP_STACK_PUT, OP_STACK_GET,
        OP_IDLE, OP_DOZE, OP_WD_RESTART, OP_DEBUG_HALT, OP_ILLEGAL
    } fmc_op_type;

    // data memory request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic re;
        logic we;
    } fmc_dmem_type;

    // program memory request (byte address, word write data)
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic re;
        logic we;
    } fmc_pmem_type;

    // i/o space request
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic re;
        logic we;
    } fmc_io_type;

endpackage
